// *** core/pdc_pkg.sv ***
// Constants for the endpoint capability register pair
// What this block does
// - Reserved bits of both capability registers always read as zero.
// - Bits 13:9 of the 16-bit register show the interrupt message number.
// - Slot implemented bit 8 always reads zero, writes ignored.
// - Bits 7:4 report the fixed endpoint port type code 0000b.
// - Bits 3:0 report capability version two, code 0010b.
// - 16-bit capability register sits at offset 72h, resets to 0002h.
// - 32-bit device capability register at 74h, resets 0000_8FC3h, read-only.
// - Function level reset capable bit 28 reads zero.
// - Slot power message payload bits 9:8 land in scale bits 27:26.
// - Scale codes 00..11 mean multipliers 1.0, 0.1, 0.01, 0.001.
// - Slot power message payload bits 7:0 land in value bits 25:18.
// - Slot power limit equals captured value times selected scale multiplier.
// - Role based error reporting bit 15 reads constant one.
// - Bits 11:9 mirror the deep idle latency setting, default PHY latency.
// - Bits 8:6 mirror the light idle latency setting, default PHY latency.
// - Neither mirrored latency may fall below the PHY's actual exit latency.
// - Wide tag supported bit 5 reads zero.
// - Ghost function support bits 4:3 read zero.
// - Max payload supported bits 2:0 read 011b, meaning 1 Kbyte.
`default_nettype none
package pdc_pkg;
	localparam int          CFG_ADDR_W          = 12;
	// Byte offsets in configuration space
	localparam logic [11:0] OFS_EXPRESS_CAPS    = 12'h072;
	localparam logic [11:0] OFS_DEVICE_CAPS     = 12'h074;
	// Reset values
	localparam logic [15:0] EXPRESS_CAPS_RESET  = 16'h0002;
	localparam logic [31:0] DEVICE_CAPS_RESET   = 32'h0000_8FC3;
	localparam logic [4:0]  INT_NUM_RESET       = 5'h00;
	localparam logic [2:0]  DEEP_LAT_RESET      = 3'h7;
	localparam logic [2:0]  LIGHT_LAT_RESET     = 3'h7;
	localparam logic [1:0]  SCALE_RESET         = 2'h0;
	localparam logic [7:0]  VALUE_RESET         = 8'h00;
	// Fixed field codes
	localparam logic [3:0]  PORT_KIND_ENDPOINT  = 4'h0;
	localparam logic [3:0]  CAP_VERSION_TWO     = 4'h2;
	localparam logic [2:0]  MAX_PAYLOAD_1K      = 3'h3;
	localparam logic [1:0]  GHOST_FUNC_NONE     = 2'h0;
	// Slot power message payload positions
	localparam int          SPL_SCALE_LSB       = 8;
	localparam int          SPL_VALUE_LSB       = 0;
	// Scale codes and their multipliers, expressed in milliwatts per unit
	localparam logic [1:0]  SCALE_1_0           = 2'h0;
	localparam logic [1:0]  SCALE_0_1           = 2'h1;
	localparam logic [1:0]  SCALE_0_01          = 2'h2;
	localparam logic [1:0]  SCALE_0_001         = 2'h3;
	localparam logic [9:0]  MULT_MW_1_0         = 10'h3E8;
	localparam logic [9:0]  MULT_MW_0_1         = 10'h064;
	localparam logic [9:0]  MULT_MW_0_01        = 10'h00A;
	localparam logic [9:0]  MULT_MW_0_001       = 10'h001;
	localparam int          POWER_MW_W          = 18;
endpackage
`default_nettype wire

// *** core/pdc_latency_floor.sv ***
// Latency floor: keeps a programmed latency at or above the PHY's own
`default_nettype none
module pdc_latency_floor #(
	parameter int W = 3
) (
	input  wire logic [W-1:0] setting,
	input  wire logic [W-1:0] phy_floor,
	output logic      [W-1:0] limited
);
	// floor clamp: a setting below the PHY latency is raised to it
	always_comb begin
		if (setting < phy_floor) begin
			limited = phy_floor;
		end else begin
			limited = setting;
		end
	end
endmodule
`default_nettype wire

// *** core/pdc_power_limit.sv ***
// Slot power limit arithmetic from captured scale and value
`default_nettype none
module pdc_power_limit (
	input  wire logic [1:0]                    scale,
	input  wire logic [7:0]                    value,
	output logic      [pdc_pkg::POWER_MW_W-1:0] limit_mw
);
	logic [9:0]  mult;
	logic [17:0] product;

	// scale decode: each code selects a power-of-ten multiplier
	always_comb begin
		case (scale)
			pdc_pkg::SCALE_1_0:   mult = pdc_pkg::MULT_MW_1_0;
			pdc_pkg::SCALE_0_1:   mult = pdc_pkg::MULT_MW_0_1;
			pdc_pkg::SCALE_0_01:  mult = pdc_pkg::MULT_MW_0_01;
			pdc_pkg::SCALE_0_001: mult = pdc_pkg::MULT_MW_0_001;
			default:              mult = pdc_pkg::MULT_MW_1_0;
		endcase
	end

	// limit product: value times multiplier, fits in 18 bits
	assign product  = {10'h000, value} * {8'h00, mult};
	assign limit_mw = product[pdc_pkg::POWER_MW_W-1:0];
endmodule
`default_nettype wire

// *** core/pdc_capability_regs.sv ***
// Endpoint capability register pair with configuration read port
`default_nettype none
module pdc_capability_regs (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// Configuration access port
	input  wire logic        cfg_req,
	input  wire logic        cfg_wr,
	input  wire logic [11:0] cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_done,
	output logic             cfg_hit,
	output logic      [31:0] cfg_rdata,
	// Slot power limit message from the link layer
	input  wire logic        spl_msg_valid,
	input  wire logic [9:0]  spl_msg_payload,
	// Interrupt message number from the MSI logic
	input  wire logic [4:0]  int_msg_num,
	// Latency settings from the general control register, and PHY floors
	input  wire logic [2:0]  deep_idle_latency_setting,
	input  wire logic [2:0]  light_idle_latency_setting,
	input  wire logic [2:0]  phy_deep_idle_exit_latency,
	input  wire logic [2:0]  phy_light_idle_exit_latency,
	// Register views and derived results
	output logic      [15:0] express_capabilities,
	output logic      [31:0] device_capabilities,
	output logic      [17:0] slot_power_limit_mw,
	output logic             slot_power_captured
);
	// Hardware-updated fields
	logic [4:0]  int_num_reg;
	logic [4:0]  int_num_next;
	logic [1:0]  captured_power_scale_reg;
	logic [1:0]  captured_power_scale_next;
	logic [7:0]  captured_power_value_reg;
	logic [7:0]  captured_power_value_next;
	logic [2:0]  deep_idle_exit_latency_reg;
	logic [2:0]  deep_idle_exit_latency_next;
	logic [2:0]  light_idle_exit_latency_reg;
	logic [2:0]  light_idle_exit_latency_next;
	logic        captured_reg;
	logic        captured_next;
	logic [17:0] power_mw_reg;
	logic [17:0] power_mw_next;
	// Access answer state
	logic        done_reg;
	logic        done_next;
	logic        hit_reg;
	logic        hit_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	// Combinational views
	logic [2:0]  deep_limited;
	logic [2:0]  light_limited;
	logic [17:0] power_mw;
	logic [15:0] express_view;
	logic [31:0] device_view;
	logic [11:0] dword_addr;
	logic [31:0] lane_mask;

	// Both latency mirrors share one clamp design
	pdc_latency_floor #(
		.W (3)
	) u_deep_floor (
		.setting   (deep_idle_latency_setting),
		.phy_floor (phy_deep_idle_exit_latency),
		.limited   (deep_limited)
	);

	pdc_latency_floor #(
		.W (3)
	) u_light_floor (
		.setting   (light_idle_latency_setting),
		.phy_floor (phy_light_idle_exit_latency),
		.limited   (light_limited)
	);

	// Power limit computed from the stored fields, registered below
	pdc_power_limit u_power (
		.scale    (captured_power_scale_reg),
		.value    (captured_power_value_reg),
		.limit_mw (power_mw)
	);

	// Field next values; configuration writes never appear here
	always_comb begin
		// message number follows the MSI logic
		int_num_next                 = int_msg_num;
		captured_power_scale_next    = captured_power_scale_reg;
		captured_power_value_next    = captured_power_value_reg;
		captured_next                = captured_reg;
		deep_idle_exit_latency_next  = deep_limited;
		light_idle_exit_latency_next = light_limited;
		// limit follows the stored fields one cycle behind them
		power_mw_next                = power_mw;
		if (spl_msg_valid) begin
			// scale captured from payload bits 9:8
			captured_power_scale_next = spl_msg_payload[pdc_pkg::SPL_SCALE_LSB +: 2];
			// value captured from payload bits 7:0
			captured_power_value_next = spl_msg_payload[pdc_pkg::SPL_VALUE_LSB +: 8];
			captured_next             = 1'b1;
		end
	end

	// Field registers; reset values give 0002h and 0000_8FC3h
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_num_reg                 <= pdc_pkg::INT_NUM_RESET;
			captured_power_scale_reg    <= pdc_pkg::SCALE_RESET;
			captured_power_value_reg    <= pdc_pkg::VALUE_RESET;
			deep_idle_exit_latency_reg  <= pdc_pkg::DEEP_LAT_RESET;
			light_idle_exit_latency_reg <= pdc_pkg::LIGHT_LAT_RESET;
			captured_reg                <= 1'b0;
			power_mw_reg                <= 18'h00000;
		end else if (ce) begin
			int_num_reg                 <= int_num_next;
			captured_power_scale_reg    <= captured_power_scale_next;
			captured_power_value_reg    <= captured_power_value_next;
			deep_idle_exit_latency_reg  <= deep_idle_exit_latency_next;
			light_idle_exit_latency_reg <= light_idle_exit_latency_next;
			captured_reg                <= captured_next;
			power_mw_reg                <= power_mw_next;
		end
	end

	// 16-bit capability view
	always_comb begin
		express_view = 16'h0000;
		express_view[15:14] = 2'h0;
		express_view[13:9]  = int_num_reg;
		express_view[8]     = 1'b0;
		express_view[7:4]   = pdc_pkg::PORT_KIND_ENDPOINT;
		express_view[3:0]   = pdc_pkg::CAP_VERSION_TWO;
	end

	// 32-bit device capability view
	always_comb begin
		device_view = 32'h0000_0000;
		// reserved ranges 31:29, 17:16, 14:12 stay zero
		device_view[31:29] = 3'h0;
		// single function, no function level reset
		device_view[28]    = 1'b0;
		device_view[27:26] = captured_power_scale_reg;
		device_view[25:18] = captured_power_value_reg;
		device_view[15]    = 1'b1;
		device_view[11:9]  = deep_idle_exit_latency_reg;
		device_view[8:6]   = light_idle_exit_latency_reg;
		device_view[5]     = 1'b0;
		device_view[4:3]   = pdc_pkg::GHOST_FUNC_NONE;
		device_view[2:0]   = pdc_pkg::MAX_PAYLOAD_1K;
	end

	// Dword decode; lanes not enabled read zero so a neighbour can OR in
	assign dword_addr = {cfg_addr[11:2], 2'b00};
	assign lane_mask  = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

	// Access answer; one cycle after every request taken with ce high, read or write
	always_comb begin
		done_next  = 1'b0;
		hit_next   = 1'b0;
		rdata_next = 32'h0000_0000;
		if (cfg_req) begin
			done_next = 1'b1;
			// writes are answered but leave every field alone
			if (!cfg_wr) begin
				// express register in upper half of dword 70h
				if (dword_addr == {pdc_pkg::OFS_EXPRESS_CAPS[11:2], 2'b00}) begin
					hit_next   = 1'b1;
					rdata_next = {express_view, 16'h0000} & lane_mask;
				end else if (dword_addr == pdc_pkg::OFS_DEVICE_CAPS) begin
					hit_next   = 1'b1;
					rdata_next = device_view & lane_mask;
				end
			end else begin
				hit_next = (dword_addr == {pdc_pkg::OFS_EXPRESS_CAPS[11:2], 2'b00}) ||
				           (dword_addr == pdc_pkg::OFS_DEVICE_CAPS);
			end
		end
	end

	// Answer registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_reg  <= 1'b0;
			hit_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			done_reg  <= done_next;
			hit_reg   <= hit_next;
			rdata_reg <= rdata_next;
		end
	end

	// Write data is deliberately unused: both registers are read-only
	assign cfg_done             = done_reg;
	assign cfg_hit              = hit_reg;
	assign cfg_rdata            = rdata_reg;
	assign express_capabilities = express_view;
	assign device_capabilities  = device_view;
	assign slot_power_limit_mw  = power_mw_reg;
	assign slot_power_captured  = captured_reg;
endmodule
`default_nettype wire

// *** verification/pdc_regs_props.sv ***
// Checker for the capability register pair
`default_nettype none
module pdc_regs_props (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        ce,
	input wire logic        cfg_req,
	input wire logic        cfg_wr,
	input wire logic        cfg_done,
	input wire logic [31:0] cfg_rdata,
	input wire logic        spl_msg_valid,
	input wire logic [9:0]  spl_msg_payload,
	input wire logic [4:0]  int_msg_num,
	input wire logic [2:0]  deep_idle_latency_setting,
	input wire logic [2:0]  light_idle_latency_setting,
	input wire logic [2:0]  phy_deep_idle_exit_latency,
	input wire logic [2:0]  phy_light_idle_exit_latency,
	input wire logic [15:0] express_capabilities,
	input wire logic [31:0] device_capabilities,
	input wire logic [17:0] slot_power_limit_mw
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Milliwatts per unit of captured value, by scale code
	function automatic logic [9:0] mult(input logic [1:0] s);
		return s == 2'h0 ? 10'h3E8 : s == 2'h1 ? 10'h064 : s == 2'h2 ? 10'h00A : 10'h001;
	endfunction
	// Larger of setting and PHY floor
	function automatic logic [2:0] hi(input logic [2:0] a, input logic [2:0] b);
		return a > b ? a : b;
	endfunction
	chk_answer_next: assert property (ce && cfg_req |=> cfg_done)
		else $error("access not answered next cycle");
	chk_write_inert: assert property (ce && cfg_req && cfg_wr |=> cfg_rdata == 32'h0)
		else $error("write returned data");
	chk_reserved_zero: assert property (express_capabilities[15:14] == 2'h0
		&& device_capabilities[31:28] == 4'h0 && device_capabilities[17:16] == 2'h0
		&& device_capabilities[14:12] == 3'h0) else $error("reserved bits not zero");
	chk_fixed_codes: assert property (express_capabilities[8:0] == 9'h002)
		else $error("fixed capability codes wrong");
	chk_device_consts: assert property (device_capabilities[15]
		&& device_capabilities[5:0] == 6'h03) else $error("fixed device fields wrong");
	chk_int_number: assert property (ce |=> express_capabilities[13:9] == $past(int_msg_num))
		else $error("message number not shown");
	chk_deep_floor: assert property (ce |=> device_capabilities[11:9] ==
		hi($past(deep_idle_latency_setting), $past(phy_deep_idle_exit_latency)))
		else $error("deep idle latency wrong");
	chk_light_floor: assert property (ce |=> device_capabilities[8:6] ==
		hi($past(light_idle_latency_setting), $past(phy_light_idle_exit_latency)))
		else $error("light idle latency wrong");
	chk_power_capture: assert property (ce && spl_msg_valid |=>
		device_capabilities[27:18] == $past(spl_msg_payload)) else $error("payload not captured");
	chk_power_limit: assert property (ce |=> slot_power_limit_mw ==
		mult($past(device_capabilities[27:26])) * $past(device_capabilities[25:18]))
		else $error("power limit wrong");
endmodule
bind pdc_capability_regs pdc_regs_props chk (.ref_clk, .arst_n, .ce, .cfg_req, .cfg_wr,
	.cfg_done, .cfg_rdata, .spl_msg_valid, .spl_msg_payload, .int_msg_num,
	.deep_idle_latency_setting, .light_idle_latency_setting, .phy_deep_idle_exit_latency,
	.phy_light_idle_exit_latency, .express_capabilities, .device_capabilities,
	.slot_power_limit_mw);
`default_nettype wire

// *** verification/pdc_root_model.sv ***
// Root complex stand-in: configuration accesses and slot power messages
`default_nettype none
module pdc_root_model (
	input  wire logic        ref_clk,
	input  wire logic        cfg_done,
	input  wire logic        cfg_hit,
	input  wire logic [31:0] cfg_rdata,
	output logic             cfg_req,
	output logic             cfg_wr,
	output logic      [11:0] cfg_addr,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata,
	output logic             spl_msg_valid,
	output logic      [9:0]  spl_msg_payload
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle at time zero
	initial begin
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 12'hFFF;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		spl_msg_valid = 1'b0;
		spl_msg_payload = 10'h3FF;
	end
	// One access, held over its taking edge; answer read once settled
	task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
		output logic [33:0] r);
		@(posedge ref_clk) #1;
		cfg_req = 1'b1;
		cfg_wr = w;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = 32'hFFFF_FFFF;
		@(posedge ref_clk) #1;
		cfg_req = 1'b0;
		cfg_addr = ~a;
		cfg_wdata = 32'h0;
		r = {cfg_done, cfg_hit, cfg_rdata};
	endtask
	// Slot power message, one cycle; payload not left showing afterwards
	task automatic message(input logic [9:0] p);
		@(posedge ref_clk) #1;
		spl_msg_valid = 1'b1;
		spl_msg_payload = p;
		@(posedge ref_clk) #1;
		spl_msg_valid = 1'b0;
		spl_msg_payload = ~p;
	endtask
endmodule
`default_nettype wire

// *** verification/pdc_capability_regs_bench.sv ***
// Self-checking bench for the capability register pair
`default_nettype none
module pdc_capability_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic w; logic [11:0] a; logic [3:0] be; logic [33:0] r;} pdc_row_t;
	logic        ref_clk, arst_n, ce, req, wr, done, hit, sv, capt;
	logic [11:0] addr;
	logic [3:0]  be;
	logic [31:0] wd, rd, dc, de;
	logic [15:0] xc, xe;
	logic [9:0]  sp;
	logic [4:0]  imn;
	logic [2:0]  dls, lls, pdl, pll;
	logic [17:0] lim;
	logic [33:0] r;
	logic [9:0]  mul [4];
	pdc_row_t    rows [8];
	int          bad_count, check_count;
	pdc_root_model rc (.ref_clk, .cfg_done(done), .cfg_hit(hit), .cfg_rdata(rd),
		.cfg_req(req), .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd),
		.spl_msg_valid(sv), .spl_msg_payload(sp));
	pdc_capability_regs DUT (.ref_clk, .arst_n, .ce, .cfg_req(req), .cfg_wr(wr),
		.cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_done(done), .cfg_hit(hit),
		.cfg_rdata(rd), .spl_msg_valid(sv), .spl_msg_payload(sp), .int_msg_num(imn),
		.deep_idle_latency_setting(dls), .light_idle_latency_setting(lls),
		.phy_deep_idle_exit_latency(pdl), .phy_light_idle_exit_latency(pll),
		.express_capabilities(xc), .device_capabilities(dc), .slot_power_limit_mw(lim),
		.slot_power_captured(capt));
	task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Whole run is about forty cycles; this is far beyond it
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		imn = 5'h15;
		dls = 3'h2;
		pdl = 3'h4;
		lls = 3'h5;
		pll = 3'h1;
		mul = '{10'h3E8, 10'h064, 10'h00A, 10'h001};
		repeat (4) @(posedge ref_clk);
		check("express reset", 34'h0_0000_0002, 34'(xc));
		check("device reset", 34'h0_0000_8FC3, 34'(dc));
		#1 arst_n = 1'b1;
		rc.message(10'h119);
		@(posedge ref_clk) #1;
		// Floors: deep setting under PHY, light setting over it
		xe = {2'h0, 5'h15, 1'b0, 4'h0, 4'h2};
		de = {4'h0, 2'h1, 8'h19, 2'h0, 1'b1, 3'h0, 3'h4, 3'h5, 6'h03};
		rows = '{'{1'b0, 12'h074, 4'hF, {2'h3, de}}, '{1'b0, 12'h070, 4'hF, {2'h3, xe, 16'h0}},
			'{1'b0, 12'h076, 4'h3, {2'h3, 16'h0, de[15:0]}}, '{1'b0, 12'h078, 4'hF, 34'h2_0000_0000},
			'{1'b1, 12'h074, 4'hF, 34'h3_0000_0000}, '{1'b1, 12'h072, 4'hF, 34'h3_0000_0000},
			'{1'b0, 12'h070, 4'hC, {2'h3, xe, 16'h0}}, '{1'b0, 12'h074, 4'hF, {2'h3, de}}};
		foreach (rows[i]) begin
			rc.access(rows[i].w, rows[i].a, rows[i].be, r);
			check("cfg answer", rows[i].r, r);
		end
		// Every scale code, with inputs moving under the mirrors
		for (int s = 0; s < 4; s++) begin
			imn = 5'(s * 7);
			dls = 3'(s * 2);
			rc.message({2'(s), 8'hC8});
			@(posedge ref_clk) #1;
			check("scale", 34'(s), 34'(dc[27:26]));
			check("limit", 34'(mul[s] * 18'h000C8), 34'(lim));
		end
		check("captured", 34'h1, 34'(capt));
		// Clock enable low: a message and an access must both be ignored
		ce = 1'b0;
		rc.message(10'h2FF);
		rc.access(1'b0, 12'h074, 4'hF, r);
		check("frozen answer", 34'h0, r);
		check("frozen fields", 34'h0_0000_03C8, 34'(dc[27:18]));
		check("frozen limit", 34'h0_0000_00C8, 34'(lim));
		ce = 1'b1;
		// Reset in mid-run restores defaults
		arst_n = 1'b0;
		#1;
		check("device again", 34'h0_0000_8FC3, 34'(dc));
		check("limit cleared", 34'h0, 34'({capt, lim}));
		@(posedge ref_clk) #1 arst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		// Mirrors and message number reload on the first edge after release
		check("mirrors after reset", 34'h35, 34'(dc[11:6]));
		check("express after reset", 34'h0_0000_2A02, 34'(xc));
		wrap_up();
	end
endmodule
`default_nettype wire
